// >>> rtl/mpio_pkg.sv
package mpio_pkg;
	// register offsets on the plain register port
	localparam logic [15:0] MPIO_DIR_OFFSET = 16'hFFB5;
	localparam logic [15:0] MPIO_DATA_OFFSET = 16'hFFB7;
	localparam logic [7:0] MPIO_DIR_RESET = 8'h00;
	localparam logic [7:0] MPIO_DATA_RESET = 8'h00;
	localparam logic [7:0] MPIO_DIR_READ = 8'hFF;
	localparam logic [7:0] MPIO_UNMAPPED_READ = 8'h00;
	// pin positions
	localparam int MPIO_PIN_TCI0 = 0;
	localparam int MPIO_PIN_TCO0 = 1;
	localparam int MPIO_PIN_TRI0 = 2;
	localparam int MPIO_PIN_TCI1 = 3;
	localparam int MPIO_PIN_TCO1 = 4;
	localparam int MPIO_PIN_TRI1 = 5;
	localparam int MPIO_PIN_PWM0 = 6;
	localparam int MPIO_PIN_PWM1 = 7;
	localparam logic [1:0] MPIO_CCLR_RESET_SEL = 2'h3;
	localparam logic [3:0] MPIO_OS_NONE = 4'h0;
	// operating states of the port
	typedef enum logic [2:0] {
		MPIO_ST_RUN = 3'h1,
		MPIO_ST_SWSTBY = 3'h2,
		MPIO_ST_HWSTBY = 3'h4
	} mpio_state_e;
endpackage

// >>> rtl/mpio_pin_mux.sv
`timescale 1ns/100ps
module mpio_pin_mux
	import mpio_pkg::*;
(
	// general purpose setting
	input wire logic dir_i,
	input wire logic data_i,
	// peripheral claim
	input wire logic periph_own_i,
	input wire logic periph_out_i,
	// host request claim
	input wire logic host_own_i,
	input wire logic host_out_i,
	// pin
	output logic pin_o,
	output logic pin_oe_o
);
	// peripheral wins over host request, host over general output
	always_comb begin
		if (periph_own_i) begin
			pin_o = periph_out_i;
			pin_oe_o = 1'b1;
		end else if (host_own_i) begin
			pin_o = host_out_i;
			pin_oe_o = 1'b1;
		end else begin
			pin_o = data_i;
			pin_oe_o = dir_i;
		end
	end
endmodule

// >>> rtl/mpio_port.sv
`timescale 1ns/100ps
module mpio_port
	import mpio_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// register port
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	// mode and standby
	input wire logic host_port_select_i,
	input wire logic sw_standby_i,
	input wire logic hw_standby_i,
	// pwm timers
	input wire logic [1:0] pwm_out_enable_i,
	input wire logic [1:0] pulse_width_out_i,
	// 8-bit timers
	input wire logic [3:0] compare_out_select_i,
	input wire logic [1:0] counter_clear_select_i,
	input wire logic [1:0] timer_compare_output_i,
	input wire logic timer0_compare_own_i,
	output logic [1:0] timer_clock_input_o,
	output logic [1:0] timer_reset_input_o,
	output logic timer1_reset_enable_o,
	output logic periph_reset_o,
	// host requests
	input wire logic host_irq_line_a_i,
	input wire logic host_irq_line_b_i,
	input wire logic host_irq_line_c_i,
	// pins
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_o
);
	logic [7:0] pin_direction_b_q;
	logic [7:0] pin_data_latch_b_q;
	logic [7:0] reg_rdata_q;
	mpio_state_e state_q;
	logic slave_mode;
	logic [7:0] periph_own;
	logic [7:0] periph_out;
	logic [7:0] host_own;
	logic [7:0] host_out;
	logic [7:0] port_read;
	logic sel_dir;
	logic sel_data;

	assign sel_dir = (reg_addr_i == MPIO_DIR_OFFSET);
	assign sel_data = (reg_addr_i == MPIO_DATA_OFFSET);

	// standby tracking; hardware standby dominates
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= MPIO_ST_RUN;
		end else if (hw_standby_i) begin
			state_q <= MPIO_ST_HWSTBY;
		end else if (sw_standby_i) begin
			state_q <= MPIO_ST_SWSTBY;
		end else begin
			state_q <= MPIO_ST_RUN;
		end
	end

	// direction register
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_direction_b_q <= MPIO_DIR_RESET;
		end else if (hw_standby_i) begin
			pin_direction_b_q <= MPIO_DIR_RESET;
		end else if (reg_write_i && sel_dir && !sw_standby_i) begin
			pin_direction_b_q <= reg_wdata_i;
		end
		// software standby leaves the value alone
	end

	// data latch
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_data_latch_b_q <= MPIO_DATA_RESET;
		end else if (hw_standby_i) begin
			pin_data_latch_b_q <= MPIO_DATA_RESET;
		end else if (reg_write_i && sel_data && !sw_standby_i) begin
			pin_data_latch_b_q <= reg_wdata_i;
		end
	end

	// mode decode
	assign slave_mode = host_port_select_i;
	assign periph_reset_o = (state_q != MPIO_ST_RUN);

	// peripheral claims, released while any standby holds
	always_comb begin
		periph_own = 8'h00;
		periph_out = 8'h00;
		host_own = 8'h00;
		host_out = 8'h00;
		if (state_q == MPIO_ST_RUN) begin
			periph_own[MPIO_PIN_PWM1] = pwm_out_enable_i[1];
			periph_out[MPIO_PIN_PWM1] = pulse_width_out_i[1];
			periph_own[MPIO_PIN_PWM0] = pwm_out_enable_i[0];
			periph_out[MPIO_PIN_PWM0] = pulse_width_out_i[0];
			periph_own[MPIO_PIN_TCO1] = (compare_out_select_i != MPIO_OS_NONE);
			periph_out[MPIO_PIN_TCO1] = timer_compare_output_i[1];
			periph_own[MPIO_PIN_TCO0] = timer0_compare_own_i;
			periph_out[MPIO_PIN_TCO0] = timer_compare_output_i[0];
		end
		// host lines follow the general direction bit in slave mode
		if (slave_mode && state_q == MPIO_ST_RUN) begin
			host_own[MPIO_PIN_TCI1] = pin_direction_b_q[MPIO_PIN_TCI1];
			host_out[MPIO_PIN_TCI1] = host_irq_line_a_i;
			host_own[MPIO_PIN_TCO1] = pin_direction_b_q[MPIO_PIN_TCO1];
			host_out[MPIO_PIN_TCO1] = host_irq_line_b_i;
			host_own[MPIO_PIN_TRI1] = pin_direction_b_q[MPIO_PIN_TRI1];
			host_out[MPIO_PIN_TRI1] = host_irq_line_c_i;
		end
	end

	// per pin driver selection
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			mpio_pin_mux u_mux (
				.dir_i(pin_direction_b_q[gi] & ~(slave_mode && gi >= 3 && gi <= 5)),
				.data_i(pin_data_latch_b_q[gi]),
				.periph_own_i(periph_own[gi]),
				.periph_out_i(periph_out[gi]),
				.host_own_i(host_own[gi]),
				.host_out_i(host_out[gi]),
				.pin_o(pin_o[gi]),
				.pin_oe_o(pin_oe_o[gi])
			);
			// latched value for outputs, live level for inputs
			assign port_read[gi] = pin_direction_b_q[gi] ? pin_data_latch_b_q[gi]
				: pin_i[gi];
		end
	endgenerate

	// timer inputs are taken straight from the pin level
	assign timer_clock_input_o[0] = pin_i[MPIO_PIN_TCI0];
	assign timer_clock_input_o[1] = pin_i[MPIO_PIN_TCI1];
	assign timer_reset_input_o[0] = pin_i[MPIO_PIN_TRI0];
	assign timer_reset_input_o[1] = pin_i[MPIO_PIN_TRI1];
	assign timer1_reset_enable_o = (counter_clear_select_i == MPIO_CCLR_RESET_SEL);

	// read data, valid the cycle after the strobe only
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_q <= MPIO_UNMAPPED_READ;
		end else if (reg_read_i && sel_dir) begin
			reg_rdata_q <= MPIO_DIR_READ;
		end else if (reg_read_i && sel_data) begin
			reg_rdata_q <= port_read;
		end else begin
			reg_rdata_q <= MPIO_UNMAPPED_READ;
		end
	end
	assign reg_rdata_o = reg_rdata_q;
endmodule

// >>> tb/mpio_port_props.sv
`timescale 1ns/100ps
module mpio_port_props
	import mpio_pkg::*;
(
	// watched ports
	input wire logic core_clk_i, reset_i, reg_write_i, reg_read_i,
	input wire logic host_port_select_i, sw_standby_i, hw_standby_i,
	input wire logic timer1_reset_enable_o, periph_reset_o, host_irq_line_a_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i, reg_rdata_o, pin_o, pin_oe_o,
	input wire logic [1:0] pwm_out_enable_i, pulse_width_out_i,
	input wire logic [1:0] counter_clear_select_i, timer_compare_output_i,
	input wire logic [3:0] compare_out_select_i,
	input wire logic [7:0] pin_i,
	input wire logic [1:0] timer_clock_input_o, timer_reset_input_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	// state lags the standby inputs, so claims need two run samples
	sequence s_run;
		!sw_standby_i && !hw_standby_i ##1 !sw_standby_i && !hw_standby_i;
	endsequence
	property p_dir_rd;
		reg_read_i && reg_addr_i == MPIO_DIR_OFFSET |=> reg_rdata_o == MPIO_DIR_READ;
	endproperty
	a_dir_rd: assert property (p_dir_rd) else $error("dir read");
	property p_pwm;
		s_run ##0 pwm_out_enable_i[1] |-> pin_oe_o[7] && pin_o[7] == pulse_width_out_i[1];
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm pin");
	property p_cmp;
		s_run ##0 compare_out_select_i != MPIO_OS_NONE |-> pin_oe_o[4] && pin_o[4] == timer_compare_output_i[1];
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare pin");
	property p_trst;
		timer1_reset_enable_o == (counter_clear_select_i == MPIO_CCLR_RESET_SEL);
	endproperty
	a_trst: assert property (p_trst) else $error("reset enable");
	property p_host;
		s_run ##0 host_port_select_i && pin_oe_o[3] |-> pin_o[3] == host_irq_line_a_i;
	endproperty
	a_host: assert property (p_host) else $error("host pin");
	property p_dir_wr;
		s_run ##0 reg_write_i && reg_addr_i == MPIO_DIR_OFFSET |=> (pin_oe_o & 8'h05) == ($past(reg_wdata_i) & 8'h05);
	endproperty
	a_dir_wr: assert property (p_dir_wr) else $error("dir write");
	property p_hw;
		hw_standby_i |=> (pin_oe_o & 8'h05) == 8'h00;
	endproperty
	a_hw: assert property (p_hw) else $error("hw clear");
	property p_per;
		sw_standby_i [*2] |=> periph_reset_o;
	endproperty
	a_per: assert property (p_per) else $error("periph reset");
	// timer inputs follow the pin level whatever owns the pin
	property p_tin;
		timer_clock_input_o == {pin_i[3], pin_i[0]} && timer_reset_input_o == {pin_i[5], pin_i[2]};
	endproperty
	a_tin: assert property (p_tin) else $error("timer inputs");
endmodule

// >>> tb/mpio_pin_model.sv
`timescale 1ns/100ps
module mpio_pin_model (
	// port side and far side
	input wire logic [7:0] drv_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] ext_i,
	input wire logic fight_i,
	output logic [7:0] level_o
);
	// fight: an overdriven pin reads back inverted, only the latch can match
	assign level_o = (oe_i & (drv_i ^ {8{fight_i}})) | (~oe_i & ext_i);
endmodule

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
	import mpio_pkg::*;
	logic core_clk_i, reset_i, wr, rd, hps, sws, hws, t0own, fight;
	logic [15:0] addr;
	logic [7:0] wd, rdata, pin_i, pin_o, pin_oe, ext, d, v, c;
	logic [1:0] pwe, pwo, ccs, tco;
	logic [3:0] cos;
	logic [2:0] irq;
	int n_errors, n_checks;
	mpio_port u_dut (.core_clk_i, .reset_i, .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .host_port_select_i(hps),
		.sw_standby_i(sws), .hw_standby_i(hws), .pwm_out_enable_i(pwe),
		.pulse_width_out_i(pwo), .compare_out_select_i(cos), .counter_clear_select_i(ccs),
		.timer_compare_output_i(tco), .timer0_compare_own_i(t0own), .timer_clock_input_o(),
		.timer_reset_input_o(), .timer1_reset_enable_o(), .periph_reset_o(),
		.host_irq_line_a_i(irq[0]), .host_irq_line_b_i(irq[1]), .host_irq_line_c_i(irq[2]),
		.pin_i, .pin_o, .pin_oe_o(pin_oe));
	mpio_pin_model u_pins (.drv_i(pin_o), .oe_i(pin_oe), .ext_i(ext), .fight_i(fight),
		.level_o(pin_i));
	function automatic logic [7:0] exp_out(logic [7:0] d, logic [7:0] v, logic [2:0] q, logic s);
		return s ? d & (v & 8'hC7 | {2'h0, q, 3'h0}) : d & v;
	endfunction
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t exp %h got %h", $time, exp, got);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] x);
		@(posedge core_clk_i);
		{wr, rd, addr, wd} <= {w, !w, a, x};
		@(posedge core_clk_i);
		{wr, rd} <= 2'h0;
		@(negedge core_clk_i);
	endtask
	initial begin
		core_clk_i = 0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	// no wait is open ended; this only guards a stuck run
	initial begin
		#1ms;
		n_errors++;
		end_of_test();
	end
	initial begin
		{reset_i, wr, rd, hps, sws, hws, t0own, fight} = 8'h80;
		{addr, wd, ext, pwe, pwo, ccs, tco, cos, irq} = '0;
		void'($urandom(32'h27AC));
		repeat (16) @(posedge core_clk_i);
		reset_i <= 0;
		#1 chk(8'h00, pin_oe);
		acc(0, MPIO_DIR_OFFSET, 0);
		chk(MPIO_DIR_READ, rdata);
		for (int i = 0; i < 40; i++) begin
			{d, v} = $urandom;
			if (i < 2) d = {8{i[0]}};
			@(posedge core_clk_i);
			{ext, fight, ccs, pwo, tco, irq} <= $urandom;
			hps <= i >= 20;
			acc(1, MPIO_DIR_OFFSET, d);
			acc(1, MPIO_DATA_OFFSET, v);
			chk(d, pin_oe);
			chk(exp_out(d, v, irq, hps), pin_o & d);
			acc(0, MPIO_DATA_OFFSET, 0);
			chk(v & d | ext & ~d, rdata);
		end
		@(posedge core_clk_i);
		{pwe, cos, t0own, hps, fight} <= {2'h3, 4'h9, 3'h4};
		acc(1, MPIO_DIR_OFFSET, 8'h00);
		c = {pwo, 1'b0, tco[1], 2'h0, tco[0], 1'b0};
		chk(8'hD2, pin_oe);
		chk(c, pin_o & 8'hD2);
		acc(0, MPIO_DATA_OFFSET, 0);
		chk(c | ext & 8'h2D, rdata);
		acc(1, MPIO_DIR_OFFSET, 8'h0F);
		acc(1, MPIO_DATA_OFFSET, 8'h05);
		@(posedge core_clk_i);
		sws <= 1;
		repeat (2) @(posedge core_clk_i);
		@(negedge core_clk_i);
		chk(8'h0F, pin_oe);
		chk(8'h05, pin_o & 8'h0F);
		@(posedge core_clk_i);
		{sws, pwe, cos, t0own} <= '0;
		acc(0, MPIO_DATA_OFFSET, 0);
		chk(8'h05 | ext & 8'hF0, rdata);
		@(posedge core_clk_i);
		hws <= 1;
		repeat (2) @(posedge core_clk_i);
		hws <= 0;
		@(negedge core_clk_i);
		chk(8'h00, pin_oe);
		acc(1, MPIO_DIR_OFFSET, 8'hFF);
		acc(0, MPIO_DATA_OFFSET, 0);
		chk(MPIO_DATA_RESET, rdata);
		end_of_test();
	end
endmodule
bind mpio_port mpio_port_props u_props (.*);
